// ===== ws_param_map.svh
// Offsets, field limits, reset values and timing figures of the parameter record.
// Assumes inclusion by ws_pkg users; definitions only.
`ifndef WS_PARAM_MAP_SVH
`define WS_PARAM_MAP_SVH
`define WS_REC_INDEX 16'h0001
`define WS_OFF_AVG_METHOD 8'h00
`define WS_OFF_AVG_WINDOW 8'h02
`define WS_OFF_FAIL_TIMEOUT 8'h04
`define WS_OFF_HEAT_TEMP 8'h08
`define WS_OFF_HEAT_VOLT 8'h0a
`define WS_OFF_HEAT_POLICY 8'h0c
`define WS_OFF_MEAS_INTERVAL 8'h0e
`define WS_OFF_HEADING 8'h10
`define WS_OFF_SPEED_LIMIT 8'h12
`define WS_RST_AVG_METHOD 16'h0001
`define WS_RST_AVG_WINDOW 16'h000a
`define WS_RST_FAIL_TIMEOUT 16'h001e
`define WS_RST_HEAT_TEMP 16'h0008
`define WS_RST_HEAT_VOLT 16'h000a
`define WS_RST_HEAT_POLICY 16'h0001
`define WS_RST_MEAS_INTERVAL 16'h0014
`define WS_RST_HEADING 16'h0000
`define WS_RST_SPEED_LIMIT 16'h0006
`define WS_MAX_AVG_METHOD 16'h0003
`define WS_MAX_AVG_WINDOW 16'h04b0
`define WS_MIN_FAIL_TIMEOUT 16'h000a
`define WS_MAX_FAIL_TIMEOUT 16'h003c
`define WS_MIN_HEAT_TEMP 16'h0002
`define WS_MAX_HEAT_TEMP 16'h000f
`define WS_MIN_HEAT_VOLT 16'h0005
`define WS_MAX_HEAT_VOLT 16'h0030
`define WS_MAX_HEAT_POLICY 16'h0002
`define WS_MIN_MEAS_INTERVAL 16'h0014
`define WS_MAX_MEAS_INTERVAL 16'h3a98
`define WS_MAX_HEADING 16'h0167
`define WS_MIN_SPEED_LIMIT 16'h0003
`define WS_MAX_SPEED_LIMIT 16'h000a
`define WS_CLK_PERIOD_NS 10
`define WS_TICK_PERIOD_NS 1000000
`define WS_SLOT_MS 100
`define WS_SEC_MS 1000
`define WS_VOLT_HYST_V 2
`define WS_TENTHS 10
`define WS_DIR_FULL 3600
`endif

// ===== ws_pkg.sv
// Types shared by the wind sensor parameter block.
// Assumes ws_param_map.svh holds the record constants; heater policy codes are defined here.
package ws_pkg;
  // Heater policy codes
  typedef enum logic [15:0] {
    WS_HEAT_OFF = 16'h0000,
    WS_HEAT_ICE_GUARD = 16'h0001,
    WS_HEAT_AUTO = 16'h0002
  } ws_policy_t;
  // One measurement set from the transit-time front end
  typedef struct packed {
    logic valid;
    logic [15:0] speed;
    logic [11:0] dir;
    logic [11:0] vec_dir;
  } ws_sample_t;
  // Record data access from the fieldbus side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [7:0] offset;
    logic [15:0] wdata;
  } ws_rec_req_t;
  // Corrected direction outputs
  typedef struct packed {
    logic [11:0] dir;
    logic [11:0] vec_dir;
  } ws_dir_out_t;
endpackage

// ===== ws_param_ctrl.sv
// What this block does
// - Parameters travel as record index 1, unsigned 16-bit fields at fixed offsets.
// - Averaging method takes 0 to 3, four speed/angle combinations, starts at 1.
// - Averaging window in 100 ms units, 0 off, up to 1200, starts at 10.
// - Sliding window average is valid at once, over samples gathered so far.
// - No valid sample for timeout seconds sets internal and external failure flags.
// - Output period below 100 ms shrinks the timeout base by period over 100 ms.
// - Heating switches on with housing temperature above the threshold, 2 to 15.
// - Heating off below voltage threshold, back on only 2 V above it.
// - Heater policy 0 keeps every heater off under all conditions.
// - Policy 1 runs housing heater by thresholds, transducer heater only on icing.
// - Plain automatic policy switches transducer heater with the housing heater.
// - Measurement interval in 1 ms steps, 20 to 15000, sets cycle start spacing.
// - Longer acquisition raises the interval automatically; shorter never lowers it.
// - Heading offset 0 to 359 degrees is added to every measured direction.
// - Offset applies to telegram directions and to the vector component angle.
// - Speed change between samples beyond the limit, 3 to 10 m/s, is implausible.
//
// Holds the parameter record, timing, heater control, averaging store and corrections.
// Assumes all inputs are synchronous to clk_sys; speeds and angles are in tenths.
`timescale 1ns/1ns
`include "ws_param_map.svh"
module ws_param_ctrl #(
  parameter int TICK_CYCLES = `WS_TICK_PERIOD_NS / `WS_CLK_PERIOD_NS,
  parameter int AVG_DEPTH = 1200
) (
  input wire logic clk_sys, // 100 MHz system clock
  input wire logic rst_b, // Async reset, active low
  input wire ws_pkg::ws_rec_req_t rec_req, // Record read/write request
  output logic [15:0] rec_rdata, // Record read data
  output logic rec_ack, // Access taken, one cycle
  output logic rec_err, // Access refused, one cycle
  input wire ws_pkg::ws_sample_t sample, // Measurement set
  input wire logic [15:0] acq_time_ms, // Duration of four transit-time measurements
  input wire logic signed [15:0] housing_temp, // Housing temperature, 0.1 C
  input wire logic [15:0] supply_volt, // Supply voltage, 0.1 V
  input wire logic icing_detected, // Transducer icing seen
  output logic cycle_start, // Start of a measurement cycle, one cycle
  output logic housing_heater_on, // Housing heater drive
  output logic transducer_heater_on, // Transducer heater drive
  output logic fail_internal, // Measurement failure, internal flag
  output logic fail_external, // Measurement failure, external flag
  output ws_pkg::ws_dir_out_t dir_out, // North corrected directions
  output logic [31:0] avg_speed_sum, // Sum of samples in the window
  output logic [15:0] avg_count, // Number of samples in the sum
  output logic [1:0] avg_method // Averaging method in force
);
  import ws_pkg::*;

  logic [15:0] averaging_window;
  logic [15:0] failure_timeout;
  logic [15:0] heat_temp_threshold;
  logic [15:0] heat_volt_threshold;
  logic [15:0] heater_policy;
  logic [15:0] measure_interval;
  logic [15:0] heading_offset;
  logic [15:0] speed_plausibility_limit;
  logic [16:0] tick_cnt;
  logic tick_1ms;
  logic [15:0] cycle_ms;
  logic [15:0] prev_acq;
  logic [16:0] quiet_ms;
  logic [16:0] fail_limit;
  logic [15:0] prev_speed;
  logic have_prev;
  logic speed_ok;
  logic good_sample;
  logic volt_ok;
  logic warm_enough;
  logic [12:0] next_dir;
  logic [12:0] next_vdir;
  logic rec_hit;
  logic wr_ok;
  logic [15:0] next_rdata;
  logic rec_mapped;

  // Record decode and range check; out-of-range values leave the field unchanged
  assign rec_hit = rec_req.index == `WS_REC_INDEX;
  always_comb begin
    wr_ok = 1'b0;
    next_rdata = 16'h0000;
    rec_mapped = 1'b1;
    unique case (rec_req.offset)
      `WS_OFF_AVG_METHOD: begin
        wr_ok = rec_req.wdata <= `WS_MAX_AVG_METHOD;
        next_rdata = {14'h0000, avg_method};
      end
      `WS_OFF_AVG_WINDOW: begin
        wr_ok = rec_req.wdata <= `WS_MAX_AVG_WINDOW;
        next_rdata = averaging_window;
      end
      `WS_OFF_FAIL_TIMEOUT: begin
        wr_ok = rec_req.wdata >= `WS_MIN_FAIL_TIMEOUT && rec_req.wdata <= `WS_MAX_FAIL_TIMEOUT;
        next_rdata = failure_timeout;
      end
      `WS_OFF_HEAT_TEMP: begin
        wr_ok = rec_req.wdata >= `WS_MIN_HEAT_TEMP && rec_req.wdata <= `WS_MAX_HEAT_TEMP;
        next_rdata = heat_temp_threshold;
      end
      `WS_OFF_HEAT_VOLT: begin
        wr_ok = rec_req.wdata >= `WS_MIN_HEAT_VOLT && rec_req.wdata <= `WS_MAX_HEAT_VOLT;
        next_rdata = heat_volt_threshold;
      end
      `WS_OFF_HEAT_POLICY: begin
        wr_ok = rec_req.wdata <= `WS_MAX_HEAT_POLICY;
        next_rdata = heater_policy;
      end
      `WS_OFF_MEAS_INTERVAL: begin
        wr_ok = rec_req.wdata >= `WS_MIN_MEAS_INTERVAL && rec_req.wdata <= `WS_MAX_MEAS_INTERVAL;
        next_rdata = measure_interval;
      end
      `WS_OFF_HEADING: begin
        wr_ok = rec_req.wdata <= `WS_MAX_HEADING;
        next_rdata = heading_offset;
      end
      `WS_OFF_SPEED_LIMIT: begin
        wr_ok = rec_req.wdata >= `WS_MIN_SPEED_LIMIT && rec_req.wdata <= `WS_MAX_SPEED_LIMIT;
        next_rdata = speed_plausibility_limit;
      end
      default: begin
        wr_ok = 1'b0;
        next_rdata = 16'h0000;
        rec_mapped = 1'b0;
      end
    endcase
  end

  // Answer one cycle after the request; unmapped offsets and wrong index are refused
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rec_rdata <= 16'h0000;
      rec_ack <= 1'b0;
      rec_err <= 1'b0;
    end else begin
      rec_ack <= (rec_req.rd && rec_hit && rec_mapped) || (rec_req.wr && rec_hit && wr_ok);
      rec_err <= (rec_req.rd || rec_req.wr) && !(rec_hit && (rec_req.rd ? rec_mapped : wr_ok));
      rec_rdata <= (rec_req.rd && rec_hit && rec_mapped) ? next_rdata : 16'h0000;
    end
  end

  // Parameter fields; interval also raised by a longer acquisition time
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avg_method <= 2'(`WS_RST_AVG_METHOD);
      averaging_window <= `WS_RST_AVG_WINDOW;
      failure_timeout <= `WS_RST_FAIL_TIMEOUT;
      heat_temp_threshold <= `WS_RST_HEAT_TEMP;
      heat_volt_threshold <= `WS_RST_HEAT_VOLT;
      heater_policy <= `WS_RST_HEAT_POLICY;
      measure_interval <= `WS_RST_MEAS_INTERVAL;
      heading_offset <= `WS_RST_HEADING;
      speed_plausibility_limit <= `WS_RST_SPEED_LIMIT;
      prev_acq <= 16'h0000;
    end else begin
      prev_acq <= acq_time_ms;
      if (acq_time_ms > prev_acq && measure_interval <= acq_time_ms) begin
        measure_interval <= acq_time_ms + 16'h0001;
      end else if (rec_req.wr && rec_hit && wr_ok && rec_req.offset == `WS_OFF_MEAS_INTERVAL) begin
        measure_interval <= rec_req.wdata;
      end
      if (rec_req.wr && rec_hit && wr_ok) begin
        unique case (rec_req.offset)
          `WS_OFF_AVG_METHOD: avg_method <= rec_req.wdata[1:0];
          `WS_OFF_AVG_WINDOW: averaging_window <= rec_req.wdata;
          `WS_OFF_FAIL_TIMEOUT: failure_timeout <= rec_req.wdata;
          `WS_OFF_HEAT_TEMP: heat_temp_threshold <= rec_req.wdata;
          `WS_OFF_HEAT_VOLT: heat_volt_threshold <= rec_req.wdata;
          `WS_OFF_HEAT_POLICY: heater_policy <= rec_req.wdata;
          `WS_OFF_HEADING: heading_offset <= rec_req.wdata;
          `WS_OFF_SPEED_LIMIT: speed_plausibility_limit <= rec_req.wdata;
          default: ;
        endcase
      end
    end
  end

  // 1 ms time base from the system clock
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt <= 17'h00000;
      tick_1ms <= 1'b0;
    end else begin
      tick_1ms <= tick_cnt == 17'(TICK_CYCLES - 1);
      tick_cnt <= (tick_cnt == 17'(TICK_CYCLES - 1)) ? 17'h00000 : tick_cnt + 17'h00001;
    end
  end

  // Cycle spacing counted from one start to the next
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cycle_ms <= 16'h0000;
      cycle_start <= 1'b0;
    end else begin
      cycle_start <= 1'b0;
      if (tick_1ms) begin
        if (cycle_ms + 16'h0001 >= measure_interval) begin
          cycle_ms <= 16'h0000;
          cycle_start <= 1'b1;
        end else begin
          cycle_ms <= cycle_ms + 16'h0001;
        end
      end
    end
  end

  // Plausibility: a jump beyond the limit is not a valid sample
  always_comb begin
    speed_ok = 1'b1;
    if (have_prev) begin
      if (sample.speed > prev_speed) begin
        speed_ok = sample.speed - prev_speed <= 16'(speed_plausibility_limit * `WS_TENTHS);
      end else begin
        speed_ok = prev_speed - sample.speed <= 16'(speed_plausibility_limit * `WS_TENTHS);
      end
    end
  end
  assign good_sample = sample.valid && speed_ok;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev_speed <= 16'h0000;
      have_prev <= 1'b0;
    end else if (good_sample) begin
      prev_speed <= sample.speed;
      have_prev <= 1'b1;
    end
  end

  // Timeout in ms; short intervals scale the second down to interval times ten
  assign fail_limit = (measure_interval < 16'(`WS_SLOT_MS)) ?
    17'(failure_timeout * measure_interval * `WS_TENTHS) :
    17'(failure_timeout * `WS_SEC_MS);

  // A good sample wins over a timeout in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      quiet_ms <= 17'h00000;
      fail_internal <= 1'b0;
      fail_external <= 1'b0;
    end else if (good_sample) begin
      quiet_ms <= 17'h00000;
      fail_internal <= 1'b0;
      fail_external <= 1'b0;
    end else if (tick_1ms) begin
      if (quiet_ms + 17'h00001 >= fail_limit) begin
        fail_internal <= 1'b1;
        fail_external <= 1'b1;
      end else begin
        quiet_ms <= quiet_ms + 17'h00001;
      end
    end
  end

  // Supply hysteresis and temperature condition; the switch point follows the wording
  assign warm_enough = housing_temp > $signed({1'b0, 15'(heat_temp_threshold * `WS_TENTHS)});
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      volt_ok <= 1'b1;
    end else if (supply_volt < 16'(heat_volt_threshold * `WS_TENTHS)) begin
      volt_ok <= 1'b0;
    end else if (supply_volt > 16'((heat_volt_threshold + `WS_VOLT_HYST_V) * `WS_TENTHS)) begin
      volt_ok <= 1'b1;
    end
  end

  // Heater outputs by policy
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      housing_heater_on <= 1'b0;
      transducer_heater_on <= 1'b0;
    end else begin
      unique case (ws_policy_t'(heater_policy))
        WS_HEAT_OFF: begin
          housing_heater_on <= 1'b0;
          transducer_heater_on <= 1'b0;
        end
        WS_HEAT_ICE_GUARD: begin
          housing_heater_on <= warm_enough && volt_ok;
          transducer_heater_on <= icing_detected && volt_ok;
        end
        default: begin
          housing_heater_on <= warm_enough && volt_ok;
          transducer_heater_on <= warm_enough && volt_ok;
        end
      endcase
    end
  end

  // North correction on both angle paths, wrapped into one turn
  assign next_dir = 13'(sample.dir) + 13'(heading_offset * `WS_TENTHS);
  assign next_vdir = 13'(sample.vec_dir) + 13'(heading_offset * `WS_TENTHS);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dir_out <= '0;
    end else if (good_sample) begin
      dir_out.dir <= 12'((next_dir >= 13'(`WS_DIR_FULL)) ? next_dir - 13'(`WS_DIR_FULL) : next_dir);
      dir_out.vec_dir <= 12'((next_vdir >= 13'(`WS_DIR_FULL)) ?
        next_vdir - 13'(`WS_DIR_FULL) : next_vdir);
    end
  end

  // Sliding store of 100 ms slots; slot sums age out one by one
  logic [23:0] slot_sum [AVG_DEPTH];
  logic [7:0] slot_cnt [AVG_DEPTH];
  logic [10:0] wr_ptr;
  logic [10:0] old_ptr;
  logic [10:0] filled;
  logic [6:0] slot_ms;
  logic [23:0] cur_sum;
  logic [7:0] cur_cnt;
  logic [31:0] win_sum;
  logic [15:0] win_cnt;
  logic win_full;
  logic restart;
  assign restart = rec_req.wr && rec_hit && wr_ok && rec_req.offset == `WS_OFF_AVG_WINDOW;
  assign win_full = filled >= 11'(averaging_window);
  assign old_ptr = (wr_ptr >= 11'(averaging_window)) ? wr_ptr - 11'(averaging_window) :
    11'(wr_ptr + 11'(AVG_DEPTH) - 11'(averaging_window));

  always_ff @(posedge clk_sys) begin
    if (tick_1ms && slot_ms == 7'(`WS_SLOT_MS - 1)) begin
      slot_sum[wr_ptr] <= cur_sum;
      slot_cnt[wr_ptr] <= cur_cnt;
    end
  end

  // Window shorter than full averages only what has arrived
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= 11'h000;
      filled <= 11'h000;
      slot_ms <= 7'h00;
      cur_sum <= 24'h000000;
      cur_cnt <= 8'h00;
      win_sum <= 32'h00000000;
      win_cnt <= 16'h0000;
    end else if (restart) begin
      filled <= 11'h000;
      win_sum <= 32'h00000000;
      win_cnt <= 16'h0000;
    end else if (tick_1ms && slot_ms == 7'(`WS_SLOT_MS - 1)) begin
      slot_ms <= 7'h00;
      cur_sum <= good_sample ? 24'(sample.speed) : 24'h000000;
      cur_cnt <= good_sample ? 8'h01 : 8'h00;
      wr_ptr <= (wr_ptr == 11'(AVG_DEPTH - 1)) ? 11'h000 : wr_ptr + 11'h001;
      if (win_full) begin
        win_sum <= win_sum + 32'(cur_sum) - 32'(slot_sum[old_ptr]);
        win_cnt <= win_cnt + 16'(cur_cnt) - 16'(slot_cnt[old_ptr]);
      end else begin
        filled <= filled + 11'h001;
        win_sum <= win_sum + 32'(cur_sum);
        win_cnt <= win_cnt + 16'(cur_cnt);
      end
    end else begin
      slot_ms <= tick_1ms ? slot_ms + 7'h01 : slot_ms;
      if (good_sample) begin
        cur_sum <= cur_sum + 24'(sample.speed);
        cur_cnt <= cur_cnt + 8'h01;
      end
    end
  end

  // Window 0 passes the latest sample straight through
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avg_speed_sum <= 32'h00000000;
      avg_count <= 16'h0000;
    end else if (averaging_window == 16'h0000) begin
      if (good_sample) begin
        avg_speed_sum <= 32'(sample.speed);
        avg_count <= 16'h0001;
      end
    end else begin
      avg_speed_sum <= win_sum;
      avg_count <= win_cnt;
    end
  end

  property p_heat_off;
    @(posedge clk_sys) disable iff (!rst_b)
    heater_policy == 16'h0000 |=> !housing_heater_on && !transducer_heater_on;
  endproperty
  a_heat_off: assert property (p_heat_off) else $error("heater on with policy off");

  property p_volt_low;
    @(posedge clk_sys) disable iff (!rst_b)
    supply_volt < 16'(heat_volt_threshold * 10) ##1 $stable(heat_volt_threshold) |=> !housing_heater_on;
  endproperty
  a_volt_low: assert property (p_volt_low) else $error("heater on at low supply");

  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_b)
    dir_out.dir < 12'he10 && dir_out.vec_dir < 12'he10;
  endproperty
  a_wrap: assert property (p_wrap) else $error("direction out of one turn");

  property p_cycle;
    @(posedge clk_sys) disable iff (!rst_b)
    cycle_start |=> !cycle_start [*8];
  endproperty
  a_cycle: assert property (p_cycle) else $error("cycle starts too close");

  property p_fail_pair;
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(fail_internal) |-> fail_external && !$past(good_sample);
  endproperty
  a_fail_pair: assert property (p_fail_pair) else $error("failure flags disagree");

  property p_rec_ack;
    @(posedge clk_sys) disable iff (!rst_b)
    rec_req.rd && rec_req.index != 16'h0001 |=> rec_err && !rec_ack && rec_rdata == 16'h0000;
  endproperty
  a_rec_ack: assert property (p_rec_ack) else $error("wrong record index answered");

  property p_raise;
    @(posedge clk_sys) disable iff (!rst_b)
    acq_time_ms > prev_acq && measure_interval <= acq_time_ms |=> measure_interval > $past(acq_time_ms);
  endproperty
  a_raise: assert property (p_raise) else $error("interval not raised");

  property p_ice;
    @(posedge clk_sys) disable iff (!rst_b)
    heater_policy == 16'h0001 && !icing_detected |=> !transducer_heater_on;
  endproperty
  a_ice: assert property (p_ice) else $error("transducer heated without icing");
endmodule // ws_param_ctrl

// ===== ws_plc_model.sv
// Fieldbus controller model: issues record reads and writes to the block.
// Assumes the block answers within a few clocks of the taking edge.
`timescale 1ns/1ns
module ws_plc_model (
  input wire logic clk_sys, // System clock
  input wire logic [15:0] rec_rdata, // Read data
  input wire logic rec_ack, // Access taken
  input wire logic rec_err, // Access refused
  output ws_pkg::ws_rec_req_t rec_req // Request to the device
);
  import ws_pkg::*;
  initial rec_req = '0;
  // One access; request held until its taking edge, answer awaited for a few cycles
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] off,
                        input logic [15:0] wd, output logic [15:0] rd, output logic ok);
    logic got;
    got = 1'b0;
    ok = 1'b0;
    rd = '0;
    @(posedge clk_sys);
    rec_req <= '{wr: wr, rd: !wr, index: idx, offset: off, wdata: wd};
    @(posedge clk_sys);
    rec_req <= '0;
    for (int i = 0; i < 4 && !got; i++) begin
      @(negedge clk_sys);
      if (rec_ack === 1'b1 || rec_err === 1'b1) begin
        got = 1'b1;
        ok = rec_ack;
        rd = rec_rdata;
      end
    end
  endtask
endmodule // ws_plc_model

// ===== tb_ws_param_ctrl.sv
// Self-checking bench for the parameter block, with the controller model on the record bus.
// Assumes a shortened ms tick of 10 clocks; expectations follow from that value.
`timescale 1ns/1ns
`include "ws_param_map.svh"
module tb_ws_param_ctrl;
  import ws_pkg::*;
  localparam int TICK = 10;
  localparam logic [7:0] OFFS [9] = '{`WS_OFF_AVG_METHOD, `WS_OFF_AVG_WINDOW,
    `WS_OFF_FAIL_TIMEOUT, `WS_OFF_HEAT_TEMP, `WS_OFF_HEAT_VOLT, `WS_OFF_HEAT_POLICY,
    `WS_OFF_MEAS_INTERVAL, `WS_OFF_HEADING, `WS_OFF_SPEED_LIMIT};
  localparam logic [15:0] RSTS [9] = '{16'h0001, 16'h000a, 16'h001e, 16'h0008, 16'h000a,
    16'h0001, 16'h0014, 16'h0000, 16'h0006};
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  ws_rec_req_t rec_req;
  logic [15:0] rec_rdata;
  logic rec_ack, rec_err, cycle_start, housing_heater_on, transducer_heater_on;
  logic fail_internal, fail_external;
  ws_sample_t sample = '0;
  logic [15:0] acq_time_ms = 16'h000a;
  logic signed [15:0] housing_temp = 16'sh0064;
  logic [15:0] supply_volt = 16'h00f0;
  logic icing_detected = 1'b0;
  ws_dir_out_t dir_out;
  logic [31:0] avg_speed_sum;
  logic [15:0] avg_count;
  logic [1:0] avg_method;
  int failures = 0;
  int num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  ws_plc_model ws_plc_model_inst (.clk_sys(clk_sys), .rec_rdata(rec_rdata), .rec_ack(rec_ack),
    .rec_err(rec_err), .rec_req(rec_req));
  ws_param_ctrl #(.TICK_CYCLES(TICK)) ws_param_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .rec_req(rec_req), .rec_rdata(rec_rdata), .rec_ack(rec_ack), .rec_err(rec_err),
    .sample(sample), .acq_time_ms(acq_time_ms), .housing_temp(housing_temp),
    .supply_volt(supply_volt), .icing_detected(icing_detected), .cycle_start(cycle_start),
    .housing_heater_on(housing_heater_on), .transducer_heater_on(transducer_heater_on),
    .fail_internal(fail_internal), .fail_external(fail_external), .dir_out(dir_out),
    .avg_speed_sum(avg_speed_sum), .avg_count(avg_count), .avg_method(avg_method));
  // Compare and count; four-state equality so an unknown never matches
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", n, e, g);
      failures++;
    end
  endtask
  task automatic wreg(input logic [7:0] off, input logic [15:0] v, input logic exp_ok);
    logic [15:0] d;
    logic ok;
    ws_plc_model_inst.access(1'b1, `WS_REC_INDEX, off, v, d, ok);
    chk("write taken", {31'h0, exp_ok}, {31'h0, ok});
  endtask
  task automatic rreg(input logic [7:0] off, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    ws_plc_model_inst.access(1'b0, `WS_REC_INDEX, off, 16'h0000, d, ok);
    chk("read taken", 32'h1, {31'h0, ok});
    chk("field value", {16'h0, e}, {16'h0, d});
  endtask
  // One valid sample; waits long enough for the registered outputs to follow
  task automatic send(input logic [15:0] spd, input logic [11:0] d, input logic [11:0] vd);
    @(posedge clk_sys);
    sample <= '{valid: 1'b1, speed: spd, dir: d, vec_dir: vd};
    @(posedge clk_sys);
    sample.valid <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask
  function automatic logic [11:0] exp_dir(input logic [11:0] d, input logic [15:0] h);
    return 12'((32'(d) + 32'(h) * 10) % 3600);
  endfunction
  task automatic heat(input logic [15:0] t, input logic [15:0] v, input logic ice,
                      input logic eh, input logic et);
    @(posedge clk_sys);
    housing_temp <= t;
    supply_volt <= v;
    icing_detected <= ice;
    repeat (4) @(posedge clk_sys);
    chk("housing heater", {31'h0, eh}, {31'h0, housing_heater_on});
    chk("transducer heater", {31'h0, et}, {31'h0, transducer_heater_on});
  endtask
  task automatic give_verdict();
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog well beyond the longest timeout wait of about 21000 clocks
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    give_verdict();
  end
  initial begin
    logic [15:0] h, d16, spd;
    logic [11:0] d, vd;
    logic ok;
    int gap;
    h = 16'($urandom(32'heba3));
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) rreg(OFFS[i], RSTS[i]);
    chk("method out", 32'h1, {30'h0, avg_method});
    ws_plc_model_inst.access(1'b0, 16'h0002, 8'h00, 16'h0, d16, ok);
    chk("wrong index", 32'h0, {31'h0, ok});
    ws_plc_model_inst.access(1'b0, `WS_REC_INDEX, 8'h06, 16'h0, d16, ok);
    chk("unmapped offset", 32'h0, {31'h0, ok});
    $display("record map test done");
    for (int m = 0; m < 4; m++) begin
      wreg(`WS_OFF_AVG_METHOD, 16'(m), 1'b1);
      chk("method out", 32'(m), {30'h0, avg_method});
    end
    wreg(`WS_OFF_AVG_METHOD, 16'h0004, 1'b0);
    wreg(`WS_OFF_AVG_WINDOW, 16'h04b1, 1'b0);
    wreg(`WS_OFF_HEADING, 16'h0168, 1'b0);
    wreg(`WS_OFF_MEAS_INTERVAL, 16'h0013, 1'b0);
    rreg(`WS_OFF_HEADING, 16'h0000);
    $display("field range test done");
    for (int k = 0; k < 6; k++) begin
      h = (k == 0) ? 16'h0167 : 16'($urandom % 360);
      d = (k == 0) ? 12'hd0b : 12'($urandom % 3600);
      vd = 12'($urandom % 3600);
      wreg(`WS_OFF_HEADING, h, 1'b1);
      send(16'h0014, d, vd);
      chk("direction", {20'h0, exp_dir(d, h)}, {20'h0, dir_out.dir});
      chk("vector angle", {20'h0, exp_dir(vd, h)}, {20'h0, dir_out.vec_dir});
    end
    send(16'h00c8, 12'h005, 12'h005);
    chk("implausible kept out", {20'h0, exp_dir(d, h)}, {20'h0, dir_out.dir});
    $display("direction test done");
    wreg(`WS_OFF_AVG_WINDOW, 16'h0000, 1'b1);
    send(16'h0025, 12'h010, 12'h010);
    chk("window off sum", 32'h25, avg_speed_sum);
    chk("window off count", 32'h1, {16'h0, avg_count});
    wreg(`WS_OFF_AVG_WINDOW, 16'h04b0, 1'b1);
    $display("averaging test done");
    heat(16'h0064, 16'h00f0, 1'b0, 1'b1, 1'b0);
    heat(16'h0064, 16'h00f0, 1'b1, 1'b1, 1'b1);
    heat(16'h0050, 16'h00f0, 1'b0, 1'b0, 1'b0);
    heat(16'h0051, 16'h00f0, 1'b0, 1'b1, 1'b0);
    heat(16'h0064, 16'h0063, 1'b0, 1'b0, 1'b0);
    heat(16'h0064, 16'h0073, 1'b0, 1'b0, 1'b0);
    heat(16'h0064, 16'h0079, 1'b0, 1'b1, 1'b0);
    wreg(`WS_OFF_HEAT_POLICY, 16'h0000, 1'b1);
    heat(16'h0064, 16'h00f0, 1'b1, 1'b0, 1'b0);
    wreg(`WS_OFF_HEAT_POLICY, 16'h0002, 1'b1);
    heat(16'h0064, 16'h00f0, 1'b0, 1'b1, 1'b1);
    heat(16'h0064, 16'h0063, 1'b0, 1'b0, 1'b0);
    $display("heater test done");
    gap = 0;
    for (int i = 0; i < 300 && cycle_start !== 1'b1; i++) @(negedge clk_sys);
    @(negedge clk_sys);
    for (gap = 1; gap < 400 && cycle_start !== 1'b1; gap++) @(negedge clk_sys);
    chk("cycle spacing", 32'(20 * TICK), 32'(gap));
    $display("cycle test done");
    wreg(`WS_OFF_FAIL_TIMEOUT, 16'h000a, 1'b1);
    send(16'h0014, 12'h020, 12'h020);
    chk("fail int cleared", 32'h0, {31'h0, fail_internal});
    repeat (1900 * TICK) @(posedge clk_sys);
    chk("fail int early", 32'h0, {31'h0, fail_internal});
    repeat (200 * TICK) @(posedge clk_sys);
    chk("fail int", 32'h1, {31'h0, fail_internal});
    chk("fail ext", 32'h1, {31'h0, fail_external});
    $display("timeout test done");
    @(posedge clk_sys);
    acq_time_ms <= 16'h001e;
    repeat (4) @(posedge clk_sys);
    rreg(`WS_OFF_MEAS_INTERVAL, 16'h001f);
    @(posedge clk_sys);
    acq_time_ms <= 16'h0005; // kept below the interval
    repeat (4) @(posedge clk_sys);
    rreg(`WS_OFF_MEAS_INTERVAL, 16'h001f);
    $display("interval raise test done");
    // One sample in a ten-slot window: counted after its slot closes, gone ten slots on
    wreg(`WS_OFF_AVG_WINDOW, 16'h000a, 1'b1);
    spd = 16'(10 + $urandom % 60);
    send(spd, 12'h030, 12'h030);
    repeat (100 * TICK) @(posedge clk_sys);
    chk("window sum", {16'h0, spd}, avg_speed_sum);
    chk("window count", 32'h1, {16'h0, avg_count});
    repeat (1000 * TICK) @(posedge clk_sys);
    chk("window aged out", 32'h0, {16'h0, avg_count});
    $display("sliding window test done");
    give_verdict();
  end
endmodule // tb_ws_param_ctrl
